// ==== hdl/sar_adc_control_config.sv ====
// Converter control and configuration with Wishbone register access
//
// Overview of operation
// RULE1: Enable bit 7: shutdown when 0, active 1; the code stays active with bit 7 at 0 if burst bit 6 is set
// RULE2: Bit 6 enables burst operation
// RULE3: Done flag bit 5 set per conversion/burst
// RULE4: Done flag stays until software clears it
// RULE5: Writing busy bit starts only when source 000
// RULE6: Window flag bit 3 set inside thresholds
// RULE7: Source select: software, timers, external edge
// RULE8: SAR clock is source over divider plus one
// RULE9: Burst uses low-power oscillator as source
// RULE10: Bit 2 selects 8-bit conversions
// RULE11: Normal tracking converts right after start
// RULE12: Delayed tracking waits three SAR clocks
// RULE13: Bit 0 selects gain 0.5 or 1
// RULE14: 8-bit ends two clocks sooner, low zero
// RULE15: Burst starts no closer than four clocks; the code puts no minimum spacing between starts
// RULE16: Busy held from start until done
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps
`include "sar_adc_defines.svh"

module sar_adc_control_config (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [11:0] adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Start sources
  input  wire logic        timer0_overflow_i,
  input  wire logic        timer2_overflow_i,
  input  wire logic        timer3_overflow_i,
  input  wire logic        external_start_pin_i,
  // Low-power oscillator tick
  input  wire logic        lp_osc_tick_i,
  // Analog converter
  input  wire logic [9:0]  conv_data_i,
  output logic             converter_power_o,
  output logic             sar_tick_o,
  output logic             tracking_o,
  output logic             converting_o,
  output logic             eight_bit_o,
  output logic             gain_one_o,
  // Status
  output logic             busy_o,
  output logic             conversion_done_o,
  output logic             window_match_o
);

  // Decode of a register index
  function automatic logic reg_hit(input logic [9:0] adr, input logic [9:0] idx);
    reg_hit = (adr == idx);
  endfunction

  // Control fields
  logic       converter_enable;
  logic       burst_mode_enable;
  logic       conversion_done_flag;
  logic       window_match_flag;
  logic [2:0] start_source_select;

  // Configuration fields
  logic [4:0] sar_clock_divider;
  logic       eight_bit_mode_enable;
  logic       delayed_track_mode;
  logic       input_gain_select;

  // Result and window thresholds
  logic [15:0] result;
  logic [15:0] window_upper;
  logic [15:0] window_lower;

  // Sequencer
  sar_adc_pkg::conv_state_e state;
  sar_adc_pkg::conv_state_e next_state;
  logic [3:0] clk_count;
  logic [3:0] next_clk_count;
  logic       busy;
  logic       ext_pin_prev;
  logic       sar_tick;

  // Bus decode
  wire [9:0] word_adr  = adr_i[11:2];
  wire       bus_req   = cyc_i && stb_i && !ack_o;
  wire       wr_strobe = bus_req && we_i && sel_i[0];
  wire       hit_ctl   = reg_hit(word_adr, `CONTROL_IDX);
  wire       hit_cfg   = reg_hit(word_adr, `CONFIG_IDX);
  wire       hit_rlo   = reg_hit(word_adr, `RESULT_LOW_IDX);
  wire       hit_rhi   = reg_hit(word_adr, `RESULT_HIGH_IDX);
  wire       hit_ulo   = reg_hit(word_adr, `UPPER_LOW_IDX);
  wire       hit_uhi   = reg_hit(word_adr, `UPPER_HIGH_IDX);
  wire       hit_llo   = reg_hit(word_adr, `LOWER_LOW_IDX);
  wire       hit_lhi   = reg_hit(word_adr, `LOWER_HIGH_IDX);
  wire       wr_ctl    = wr_strobe && hit_ctl;
  wire       wr_cfg    = wr_strobe && hit_cfg;
  wire [7:0] wbyte     = dat_i[7:0];

  // Register read views
  wire [7:0] ctl_view = {converter_enable, burst_mode_enable,
                         conversion_done_flag, busy, window_match_flag,
                         start_source_select};
  wire [7:0] cfg_view = {sar_clock_divider, eight_bit_mode_enable,
                         delayed_track_mode, input_gain_select};
  wire [7:0] rd_byte  = hit_ctl ? ctl_view :
                        hit_cfg ? cfg_view :
                        hit_rlo ? result[7:0] :
                        hit_rhi ? result[15:8] :
                        hit_ulo ? window_upper[7:0] :
                        hit_uhi ? window_upper[15:8] :
                        hit_llo ? window_lower[7:0] :
                        hit_lhi ? window_lower[15:8] : 8'h00;

  // Start-of-conversion selection
  wire ext_rise  = external_start_pin_i && !ext_pin_prev;  // see RULE7
  wire sw_start  = wr_ctl && wbyte[`BUSY_BIT] &&
                   (start_source_select == `SRC_SOFTWARE);  // see RULE5
  wire src_start = start_source_select[2] ? ext_rise :
                   (start_source_select == `SRC_TIMER0) ? timer0_overflow_i :
                   (start_source_select == `SRC_TIMER2) ? timer2_overflow_i :
                   (start_source_select == `SRC_TIMER3) ? timer3_overflow_i :
                   sw_start;  // see RULE7
  wire active    = converter_enable || burst_mode_enable;  // see RULE1 RULE2
  wire start_ok  = src_start && active && (state == sar_adc_pkg::ST_IDLE);

  // Divider source clock
  wire src_tick  = burst_mode_enable ? lp_osc_tick_i : 1'b1;  // see RULE9

  // Conversion length
  wire [3:0] conv_clks = eight_bit_mode_enable ? `CONV_CLKS_8
                                               : `CONV_CLKS_10;  // see RULE10 RULE14
  wire track_end = sar_tick && (clk_count == `TRACK_CLKS - 4'h1);
  wire conv_end  = sar_tick && (clk_count == conv_clks - 4'h1);
  wire conv_done = (state == sar_adc_pkg::ST_CONVERT) && conv_end;  // see RULE3

  // Result formatting
  wire [15:0] next_result = eight_bit_mode_enable ?
                            {conv_data_i[9:2], 8'h00} :
                            {6'h00, conv_data_i};  // see RULE14
  wire in_window = (next_result >= window_lower) &&
                   (next_result <= window_upper);  // see RULE6

  // Flag updates, hardware set wins over software clear
  wire next_done_flag = conv_done ? 1'b1 :
                        wr_ctl ? wbyte[`DONE_BIT] : conversion_done_flag;  // see RULE4
  wire next_win_flag  = (conv_done && in_window) ? 1'b1 :
                        wr_ctl ? wbyte[`WIN_BIT] : window_match_flag;  // see RULE6

  // Sequencer next state
  always_comb begin
    next_state     = state;
    next_clk_count = clk_count;
    case (state)
      sar_adc_pkg::ST_IDLE: begin
        next_clk_count = 4'h0;
        if (start_ok) begin
          next_state = delayed_track_mode ? sar_adc_pkg::ST_TRACK
                                          : sar_adc_pkg::ST_CONVERT;  // see RULE11 RULE12
        end
      end
      sar_adc_pkg::ST_TRACK: begin
        if (track_end) begin
          next_state     = sar_adc_pkg::ST_CONVERT;  // see RULE12
          next_clk_count = 4'h0;
        end else if (sar_tick) begin
          next_clk_count = clk_count + 4'h1;
        end
      end
      sar_adc_pkg::ST_CONVERT: begin
        if (conv_end) begin
          next_state     = sar_adc_pkg::ST_IDLE;
          next_clk_count = 4'h0;
        end else if (sar_tick) begin
          next_clk_count = clk_count + 4'h1;
        end
      end
      default: begin
        next_state     = sar_adc_pkg::ST_IDLE;
        next_clk_count = 4'h0;
      end
    endcase
    if (!active) begin
      next_state     = sar_adc_pkg::ST_IDLE;  // see RULE1
      next_clk_count = 4'h0;
    end
  end

  // SAR clock divider
  sar_clock_divider u_divider (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      (next_state != sar_adc_pkg::ST_IDLE),
    .src_tick_i (src_tick),
    .div_i      (sar_clock_divider),
    .tick_o     (sar_tick)
  );

  // Bus answer, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converter_enable     <= 1'b0;
      burst_mode_enable    <= 1'b0;
      conversion_done_flag <= 1'b0;
      window_match_flag    <= 1'b0;
      start_source_select  <= 3'h0;
    end else begin
      if (wr_ctl) begin
        converter_enable    <= wbyte[`EN_BIT];  // see RULE1
        burst_mode_enable   <= wbyte[`BURST_BIT];  // see RULE2
        start_source_select <= wbyte[`SRC_MSB:`SRC_LSB];  // see RULE7
      end
      conversion_done_flag <= next_done_flag;  // see RULE3 RULE4
      window_match_flag    <= next_win_flag;  // see RULE6
    end
  end

  // Configuration register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sar_clock_divider     <= 5'h1f;
      eight_bit_mode_enable <= 1'b0;
      delayed_track_mode    <= 1'b0;
      input_gain_select     <= 1'b0;
    end else if (wr_cfg) begin
      sar_clock_divider     <= wbyte[`DIV_MSB:`DIV_LSB];  // see RULE8
      eight_bit_mode_enable <= wbyte[`EIGHT_BIT];  // see RULE10
      delayed_track_mode    <= wbyte[`TRACK_BIT];  // see RULE11 RULE12
      input_gain_select     <= wbyte[`GAIN_BIT];  // see RULE13
    end
  end

  // Window thresholds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      window_upper <= `UPPER_RESET;
      window_lower <= `LOWER_RESET;
    end else if (wr_strobe) begin
      if (hit_ulo) window_upper[7:0]  <= wbyte;
      if (hit_uhi) window_upper[15:8] <= wbyte;
      if (hit_llo) window_lower[7:0]  <= wbyte;
      if (hit_lhi) window_lower[15:8] <= wbyte;
    end
  end

  // Result capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= 16'h0000;
    end else if (conv_done) begin
      result <= next_result;  // see RULE14
    end
  end

  // Sequencer and busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= sar_adc_pkg::ST_IDLE;
      clk_count    <= 4'h0;
      busy         <= 1'b0;
      ext_pin_prev <= 1'b0;
    end else begin
      state        <= next_state;
      clk_count    <= next_clk_count;
      busy         <= (next_state != sar_adc_pkg::ST_IDLE);  // see RULE16
      ext_pin_prev <= external_start_pin_i;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converter_power_o <= 1'b0;
      sar_tick_o        <= 1'b0;
      tracking_o        <= 1'b0;
      converting_o      <= 1'b0;
      eight_bit_o       <= 1'b0;
      gain_one_o        <= 1'b0;
      busy_o            <= 1'b0;
      conversion_done_o <= 1'b0;
      window_match_o    <= 1'b0;
    end else begin
      converter_power_o <= active;  // see RULE1
      sar_tick_o        <= sar_tick;
      tracking_o        <= (next_state != sar_adc_pkg::ST_CONVERT);  // see RULE12
      converting_o      <= (next_state == sar_adc_pkg::ST_CONVERT);
      eight_bit_o       <= eight_bit_mode_enable;
      gain_one_o        <= input_gain_select;  // see RULE13
      busy_o            <= (next_state != sar_adc_pkg::ST_IDLE);  // see RULE16
      conversion_done_o <= next_done_flag;
      window_match_o    <= next_win_flag;
    end
  end

endmodule

// ==== pkg/sar_adc_defines.svh ====
// Register indices, field positions, reset values and cycle counts
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// Register indices; byte address is four times the index
`define CONFIG_IDX        10'h097
`define CONTROL_IDX       10'h0e8
`define RESULT_LOW_IDX    10'h0bd
`define RESULT_HIGH_IDX   10'h0be
`define UPPER_LOW_IDX     10'h0c3
`define UPPER_HIGH_IDX    10'h0c4
`define LOWER_LOW_IDX     10'h0c5
`define LOWER_HIGH_IDX    10'h0c6

// Reset values
`define CONFIG_RESET      8'hf8
`define CONTROL_RESET     8'h00
`define UPPER_RESET       16'hffff
`define LOWER_RESET       16'h0000

// Control register fields
`define EN_BIT            7
`define BURST_BIT         6
`define DONE_BIT          5
`define BUSY_BIT          4
`define WIN_BIT           3
`define SRC_MSB           2
`define SRC_LSB           0

// Configuration register fields
`define DIV_MSB           7
`define DIV_LSB           3
`define EIGHT_BIT         2
`define TRACK_BIT         1
`define GAIN_BIT          0

// Start source codes
`define SRC_SOFTWARE      3'h0
`define SRC_TIMER0        3'h1
`define SRC_TIMER2        3'h2
`define SRC_TIMER3        3'h3

// Counts in SAR clocks
`define TRACK_CLKS        4'h3
`define CONV_CLKS_10      4'hd
`define CONV_CLKS_8       4'hb

`endif

// ==== pkg/sar_adc_pkg.sv ====
// Types for the converter control block
package sar_adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_TRACK   = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_e;

  typedef logic [7:0] reg_byte_t;

endpackage

// ==== hdl/sar_clock_divider.sv ====
// SAR conversion clock divider producing one-cycle ticks
`timescale 1ns/10ps
`include "sar_adc_defines.svh"

module sar_clock_divider (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       run_i,
  input  wire logic       src_tick_i,
  input  wire logic [4:0] div_i,
  // Divided tick
  output logic            tick_o
);

  logic [4:0] count;
  wire        wrap = (count == div_i);

  // Tick every divider plus one source ticks (see RULE8)
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      count  <= 5'h00;
      tick_o <= 1'b0;
    end else if (src_tick_i) begin
      count  <= wrap ? 5'h00 : count + 5'h01;
      tick_o <= wrap;
    end else begin
      tick_o <= 1'b0;
    end
  end

endmodule

// ==== testbench/sar_adc_chk.sv ====
// Checker for the converter control block
`timescale 1ns/10ps
`include "sar_adc_defines.svh"
module sar_adc_chk (
  // Clock, reset, bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        we_i,
  input wire logic [3:0]  sel_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Status
  input wire logic        converter_power_o,
  input wire logic        tracking_o,
  input wire logic        converting_o,
  input wire logic        busy_o,
  input wire logic        conversion_done_o,
  input wire logic        window_match_o
);
  wire wr_ctl = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i[11:2] == `CONTROL_IDX;
  wire set_done = wr_ctl && dat_i[5];
  wire clr_done = wr_ctl && !dat_i[5];
  wire clr_win  = wr_ctl && !dat_i[3];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  done_hold_a: assert property (conversion_done_o && !clr_done |=> conversion_done_o)
    else $error("done flag lost without a clear");
  win_hold_a: assert property (window_match_o && !clr_win |=> window_match_o)
    else $error("window flag lost without a clear");
  done_busy_a: assert property ($rose(conversion_done_o) && !$past(set_done) |-> $fell(busy_o))
    else $error("done set without busy ending");
  busy_fall_a: assert property ($fell(busy_o) |-> conversion_done_o || !converter_power_o)
    else $error("busy dropped early");
  track_conv_a: assert property (converting_o |-> busy_o && !tracking_o)
    else $error("tracking during conversion");
  busy_power_a: assert property ($rose(busy_o) |-> converter_power_o)
    else $error("start while shut down");
  done_c: cover property ($rose(conversion_done_o));
  busy_c: cover property ($rose(busy_o));
  win_c: cover property ($rose(window_match_o));
endmodule

bind sar_adc_control_config sar_adc_chk u_sar_adc_chk (.clk_i(clk_i), .rst_i(rst_i),
  .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .converter_power_o(converter_power_o),
  .tracking_o(tracking_o), .converting_o(converting_o), .busy_o(busy_o),
  .conversion_done_o(conversion_done_o), .window_match_o(window_match_o));

// ==== testbench/sar_adc_control_config_bench.sv ====
// Bench for the converter control block
`timescale 1ns/10ps
`include "sar_adc_defines.svh"
module sar_adc_control_config_bench;
  localparam logic [11:0] CTL = {`CONTROL_IDX, 2'b00};
  localparam logic [11:0] CFG = {`CONFIG_IDX, 2'b00};
  localparam logic [11:0] RLO = {`RESULT_LOW_IDX, 2'b00};
  localparam logic [11:0] RHI = {`RESULT_HIGH_IDX, 2'b00};
  localparam logic [11:0] LLO = {`LOWER_LOW_IDX, 2'b00};
  logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic        t0 = 1'b0, t2 = 1'b0, t3 = 1'b0, ext = 1'b0, lp = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [9:0]  data = 10'h000;
  logic [7:0]  rd;
  logic        ack_o, power, tick, trk, cnv, eight, gain, busy, done, win;
  int          num_errors = 0, samples_checked = 0, cycles = 0;

  sar_adc_control_config u_sar_adc_control_config (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o), .timer0_overflow_i(t0), .timer2_overflow_i(t2),
    .timer3_overflow_i(t3), .external_start_pin_i(ext), .lp_osc_tick_i(lp),
    .conv_data_i(data), .converter_power_o(power), .sar_tick_o(tick), .tracking_o(trk),
    .converting_o(cnv), .eight_bit_o(eight), .gain_one_o(gain), .busy_o(busy),
    .conversion_done_o(done), .window_match_o(win));

  always #20 clk_i = ~clk_i;
  // Oscillator tick every second cycle
  always @(posedge clk_i) lp <= ~lp;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic [11:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] q);
    int k;
    @(posedge clk_i);
    adr_i <= a;
    we_i <= w;
    dat_i <= {24'h0, d};
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    q = dat_o[7:0];
    chk(ack_o, 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic run_conv(input logic [7:0] ctl, input logic [7:0] cfg, input logic [9:0] d,
                          input int src, input logic [31:0] ticks, input logic [31:0] per,
                          input logic w);
    int n, t, last, gap;
    logic [7:0] hi, lo;
    n = 0;
    last = 0;
    gap = 0;
    data <= d;
    wb(CFG, 1'b1, cfg, rd);
    wb(CFG, 1'b0, 8'h00, rd);
    chk(rd, cfg);
    chk(eight, cfg[2]);
    chk(gain, cfg[0]);
    wb(CTL, 1'b1, ctl, rd);
    wb(CTL, 1'b1, ctl | 8'h10, rd);
    if (src != 0) begin
      repeat (3) @(posedge clk_i);
      chk(busy, 1'b0);
      t0 <= src == 1;
      t2 <= src == 2;
      t3 <= src == 3;
      ext <= src == 4;
      @(posedge clk_i);
      t0 <= 1'b0;
      t2 <= 1'b0;
      t3 <= 1'b0;
    end
    for (t = 1; t < 600 && done !== 1'b1; t++) begin
      @(posedge clk_i);
      if (tick === 1'b1) begin
        if (n > 0) gap = t - last;
        n++;
        last = t;
      end
    end
    @(posedge clk_i);
    if (tick === 1'b1) n++;
    ext <= 1'b0;
    chk(n, ticks);
    chk(gap, per);
    chk(done, 1'b1);
    chk(power, 1'b1);
    chk(busy, 1'b0);
    wb(RHI, 1'b0, 8'h00, hi);
    wb(RLO, 1'b0, 8'h00, lo);
    chk({hi, lo}, cfg[2] ? {d[9:2], 8'h00} : {6'h00, d});
    wb(CTL, 1'b0, 8'h00, rd);
    chk(rd, (ctl & 8'hc7) | 8'h20 | {4'h0, w, 3'h0});
    chk(win, w);
    wb(CTL, 1'b1, 8'h00, rd);
    wb(CTL, 1'b0, 8'h00, rd);
    chk(rd, 8'h00);
    chk(power, 1'b0);
    $display("conversion test source %0d done", src);
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(CTL, 1'b0, 8'h00, rd);
    chk(rd, `CONTROL_RESET);
    sel_i <= 4'he;
    wb(CFG, 1'b1, 8'h00, rd);
    sel_i <= 4'hf;
    wb(CFG, 1'b0, 8'h00, rd);
    chk(rd, `CONFIG_RESET);
    wb(12'h000, 1'b1, 8'h5a, rd);
    wb(12'h000, 1'b0, 8'h00, rd);
    chk(rd, 8'h00);
    chk(power, 1'b0);
    $display("reset and map test done");
    wb(LLO, 1'b1, 8'hff, rd);
    run_conv(8'h80, 8'h00, 10'h010, 0, 13, 1, 1'b0);
    run_conv(8'h80, 8'h0f, 10'h3ff, 0, 14, 2, 1'b1);
    for (int s = 1; s < 5; s++) run_conv(8'h80 | s[7:0], 8'h10, 10'h155, s, 13, 3, 1'b1);
    run_conv(8'h40, 8'h00, 10'h0ff, 0, 13, 2, 1'b1);
    end_of_test();
  end
endmodule
